// >>> include/ftc_pkg.sv
// Package: constants and types of the front-panel tuner control sequencer
`default_nettype none
package ftc_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int DEB_MS = 10;
    localparam int SHORT_MAX_MS = 1000;
    localparam int MED_MIN_MS = 2000;
    localparam int MED_MAX_MS = 3000;
    localparam int LONG_MIN_MS = 10000;
    localparam int STEP_MS = 2;
    localparam int DEB_CYC = CYC_PER_MS * DEB_MS;
    localparam int SHORT_MAX_CYC = CYC_PER_MS * SHORT_MAX_MS;
    localparam int MED_MIN_CYC = CYC_PER_MS * MED_MIN_MS;
    localparam int MED_MAX_CYC = CYC_PER_MS * MED_MAX_MS;
    localparam int LONG_MIN_CYC = CYC_PER_MS * LONG_MIN_MS;
    localparam int STEP_CYC = CYC_PER_MS * STEP_MS;
    localparam int HOLD_W = 32;
    localparam int POS_W = 10;
    localparam logic [POS_W-1:0] POS_RST = 10'h000;
    localparam logic [POS_W-1:0] CAP_MAX = 10'h3e7;
    localparam logic [POS_W-1:0] IND_MAX = 10'h3e7;
    localparam int NUM_BTN = 3;
    localparam int BTN_MODE = 0;
    localparam int BTN_KNOB = 1;
    localparam int BTN_OUT = 2;
    localparam int MOT_CAP = 0;
    localparam int MOT_IND = 1;
    localparam int PANEL_W = 5;

    typedef enum logic [1:0] {FTC_AUTO, FTC_MANUAL, FTC_BYPASS} ftc_mode_t;
    typedef enum logic [1:0] {PR_NONE, PR_SHORT, PR_MEDIUM, PR_LONG} ftc_press_t;
    typedef enum logic [1:0] {SW_NONE, SW_OUTPUT, SW_INPUT} ftc_sw_t;
    typedef enum logic [1:0] {FT_IDLE, FT_PROMPT, FT_RUN, FT_STORE} ftc_fine_t;

    typedef struct packed {
        logic enc_b;
        logic enc_a;
        logic out_btn;
        logic knob_btn;
        logic mode_btn;
    } ftc_panel_t;

    typedef struct packed {
        logic step;
        logic up;
    } ftc_motor_t;

    typedef struct packed {
        ftc_mode_t mode;
        logic active_l;
        logic out_bal;
        logic bypass;
        logic [3:0] ant;
        logic [POS_W-1:0] cap_pos;
        logic [POS_W-1:0] ind_pos;
    } ftc_disp_t;
endpackage
`default_nettype wire

// >>> logic/ftc_debounce.sv
// Synchroniser and debounce filter for the front-panel inputs
`timescale 1ns/1ps
`default_nettype none
module ftc_debounce #(
    parameter int WIDTH = ftc_pkg::PANEL_W,
    parameter int DEB_CYC = ftc_pkg::DEB_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] clean
);
    import ftc_pkg::*;
    localparam int CNT_W = $clog2(DEB_CYC + 1);

    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce) begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    // A level is accepted only after it has held steady for DEB_CYC cycles
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic [CNT_W-1:0] cnt;
        logic level;
        assign clean[i] = level;
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                cnt <= '0;
                level <= 1'b0;
            end else if (ce) begin
                if (sync2[i] == level) begin
                    cnt <= '0;
                end else if (cnt == CNT_W'(DEB_CYC - 1)) begin
                    cnt <= '0;
                    level <= sync2[i];
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> logic/ftc_top.sv
// Front-panel control sequencer: press sorting, mode dispatch, stepper positioning
// Contract
// - Automatic mode: short mode press while tuning aborts the attempt.
// - Automatic mode, tuner idle: short mode press selects manual mode.
// - Automatic mode: long mode press opens configuration menu; medium does nothing.
// - Automatic mode, tuner idle: short knob press starts fine tune.
// - While waiting for consent, short knob press approves automatic tuning.
// - Fine tune starts from present positions, no recall from memory.
// - With radio handshake, fine tune runs alone then stores the match.
// - Without handshake, fine tune prompts for a carrier, then continues.
// - Automatic mode: short output press un-bypasses an auto-bypassed band.
// - Otherwise short output press toggles coaxial and balanced output.
// - Output-selector switch: short output press opens antenna selection menu.
// - Input-selector switch: medium output press opens radio selection menu.
// - Short mode presses step automatic to manual, then manual to bypass.
// - Manual: rotation moves active element; short knob press swaps C and L.
// - Manual display shows mode, capacitor, antenna and inductor positions.
// - Positioning commands become stepper drive of inductor and capacitor.
// - Inductor position is tracked and held within its allowed range.
// - Interrupted memory write forces re-homing of both elements at start-up.
// - Capacitor, inductor and output selection are kept updated on display.
`timescale 1ns/1ps
`default_nettype none
module ftc_top #(
    parameter int DEB_CYC_P = ftc_pkg::DEB_CYC,
    parameter int SHORT_MAX_P = ftc_pkg::SHORT_MAX_CYC,
    parameter int MED_MIN_P = ftc_pkg::MED_MIN_CYC,
    parameter int MED_MAX_P = ftc_pkg::MED_MAX_CYC,
    parameter int LONG_MIN_P = ftc_pkg::LONG_MIN_CYC,
    parameter int STEP_CYC_P = ftc_pkg::STEP_CYC,
    parameter logic [ftc_pkg::POS_W-1:0] CAP_MAX_P = ftc_pkg::CAP_MAX,
    parameter logic [ftc_pkg::POS_W-1:0] IND_MAX_P = ftc_pkg::IND_MAX
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire ftc_pkg::ftc_panel_t panel,
    input wire logic tune_busy,
    input wire logic consent_wait,
    input wire logic hs_cfg,
    input wire logic carrier_ok,
    input wire logic tune_done,
    input wire logic band_autobyp,
    input wire ftc_pkg::ftc_sw_t sw_cfg,
    input wire logic write_intr,
    input wire logic [1:0] home_sw,
    input wire logic [3:0] ant_sel,
    output logic tune_abort,
    output logic tune_consent,
    output logic cfg_menu_open,
    output logic ant_menu_open,
    output logic radio_menu_open,
    output logic unbypass_req,
    output logic fine_run,
    output logic recall_en,
    output logic prompt_carrier,
    output logic store_req,
    output ftc_pkg::ftc_motor_t cap_drv,
    output ftc_pkg::ftc_motor_t ind_drv,
    output ftc_pkg::ftc_disp_t disp
);
    import ftc_pkg::*;
    localparam int STEP_W = $clog2(STEP_CYC_P + 1);

    ftc_panel_t clean;
    ftc_debounce #(.WIDTH(PANEL_W), .DEB_CYC(DEB_CYC_P)) u_deb (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .raw(panel),
        .clean(clean)
    );

    function automatic ftc_press_t class_of(input logic [HOLD_W-1:0] held);
        if (held <= HOLD_W'(SHORT_MAX_P))
            class_of = PR_SHORT;
        else if (held >= HOLD_W'(MED_MIN_P) && held <= HOLD_W'(MED_MAX_P))
            class_of = PR_MEDIUM;
        else if (held >= HOLD_W'(LONG_MIN_P))
            class_of = PR_LONG;
        else
            class_of = PR_NONE;
    endfunction

    // Press length is measured on the debounced level and sorted at release
    wire [NUM_BTN-1:0] btn_now = {clean.out_btn, clean.knob_btn, clean.mode_btn};
    ftc_press_t [NUM_BTN-1:0] press;
    for (genvar b = 0; b < NUM_BTN; b++) begin : g_btn
        logic [HOLD_W-1:0] held;
        logic was;
        wire released = was && !btn_now[b];
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                held <= '0;
                was <= 1'b0;
                press[b] <= PR_NONE;
            end else if (ce) begin
                was <= btn_now[b];
                press[b] <= released ? class_of(held) : PR_NONE;
                if (!btn_now[b])
                    held <= '0;
                else if (held != HOLD_W'(LONG_MIN_P))
                    held <= held + 1'b1;
            end
        end
    end

    // Quadrature: a rising edge of phase A is one detent
    logic enc_a_d;
    wire enc_step = clean.enc_a && !enc_a_d;
    wire enc_cw = !clean.enc_b;

    ftc_mode_t mode, next_mode;
    ftc_fine_t fine, next_fine;
    logic active_l;
    logic out_bal;
    logic booted;

    wire in_auto = mode == FTC_AUTO;
    wire in_man = mode != FTC_AUTO;
    wire tuner_busy = tune_busy || fine != FT_IDLE;
    wire mode_short = press[BTN_MODE] == PR_SHORT;
    wire mode_long = press[BTN_MODE] == PR_LONG;
    wire knob_short = press[BTN_KNOB] == PR_SHORT;
    wire knob_med = press[BTN_KNOB] == PR_MEDIUM;
    wire knob_long = press[BTN_KNOB] == PR_LONG;
    wire out_short = press[BTN_OUT] == PR_SHORT;
    wire out_med = press[BTN_OUT] == PR_MEDIUM;
    wire sel_out = sw_cfg == SW_OUTPUT;

    wire act_abort = in_auto && mode_short && tuner_busy;
    wire act_consent = in_auto && knob_short && consent_wait;
    wire act_cfg = in_auto && mode_long;
    wire act_ant = out_short && sel_out;
    wire act_radio = out_med && sw_cfg == SW_INPUT;
    wire act_unbyp = in_auto && out_short && !sel_out && band_autobyp;
    wire act_toggle = out_short && !sel_out && !(in_auto && band_autobyp);
    wire act_swap = in_man && knob_short;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            FTC_AUTO: if (mode_short && !tuner_busy) next_mode = FTC_MANUAL;
            FTC_MANUAL: if (mode_short) next_mode = FTC_BYPASS;
            FTC_BYPASS: if (mode_short) next_mode = FTC_AUTO;
            default: next_mode = FTC_AUTO;
        endcase
    end

    always_comb begin
        next_fine = fine;
        unique case (fine)
            FT_IDLE: begin
                if (in_auto && knob_short && !consent_wait && !tuner_busy)
                    next_fine = hs_cfg ? FT_RUN : FT_PROMPT;
            end
            FT_PROMPT: if (carrier_ok) next_fine = FT_RUN;
            FT_RUN: if (tune_done) next_fine = FT_STORE;
            FT_STORE: next_fine = FT_IDLE;
        endcase
        if ((fine == FT_PROMPT || fine == FT_RUN) && mode_short)
            next_fine = FT_IDLE;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mode <= FTC_AUTO;
            fine <= FT_IDLE;
            active_l <= 1'b0;
            out_bal <= 1'b0;
            booted <= 1'b0;
            enc_a_d <= 1'b0;
        end else if (ce) begin
            mode <= next_mode;
            fine <= next_fine;
            active_l <= active_l ^ act_swap;
            out_bal <= out_bal ^ act_toggle;
            booted <= 1'b1;
            enc_a_d <= clean.enc_a;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tune_abort <= 1'b0;
            tune_consent <= 1'b0;
            cfg_menu_open <= 1'b0;
            ant_menu_open <= 1'b0;
            radio_menu_open <= 1'b0;
            unbypass_req <= 1'b0;
            fine_run <= 1'b0;
            recall_en <= 1'b0;
            prompt_carrier <= 1'b0;
            store_req <= 1'b0;
        end else if (ce) begin
            tune_abort <= act_abort;
            tune_consent <= act_consent;
            cfg_menu_open <= act_cfg;
            ant_menu_open <= act_ant;
            radio_menu_open <= act_radio;
            unbypass_req <= act_unbyp;
            fine_run <= next_fine == FT_RUN;
            recall_en <= next_mode == FTC_AUTO && next_fine == FT_IDLE;
            prompt_carrier <= next_fine == FT_PROMPT;
            store_req <= next_fine == FT_STORE;
        end
    end

    // Per-motor commands; index 0 is the capacitor, index 1 the inductor
    wire boot_home = !booted && write_intr;
    wire turn_up = in_man && enc_step && enc_cw;
    wire turn_dn = in_man && enc_step && !enc_cw;
    wire [1:0] mot_sel = active_l ? 2'b10 : 2'b01;
    wire [1:0] mot_inc = turn_up ? mot_sel : 2'b00;
    wire [1:0] mot_dec = turn_dn ? mot_sel : 2'b00;
    wire [1:0] mot_home = {boot_home || (in_man && active_l && knob_long),
                           boot_home || (in_man && !active_l && knob_med)};

    ftc_motor_t [1:0] drv;
    logic [POS_W-1:0] pos [2];
    for (genvar m = 0; m < 2; m++) begin : g_mot
        localparam logic [POS_W-1:0] MAXP = (m == MOT_IND) ? IND_MAX_P : CAP_MAX_P;
        logic [POS_W-1:0] tgt;
        logic homing;
        logic [STEP_W-1:0] tmr;
        wire tick = tmr == '0;
        wire go_up = tgt > pos[m];
        wire moving = homing || pos[m] != tgt;
        always_ff @(posedge mclk) begin
            if (!reset_n) begin
                tgt <= POS_RST;
                pos[m] <= POS_RST;
                homing <= 1'b0;
                tmr <= '0;
                drv[m] <= '0;
            end else if (ce) begin
                drv[m].step <= 1'b0;
                if (mot_home[m])
                    homing <= 1'b1;
                else if (!homing && mot_inc[m] && tgt != MAXP)
                    tgt <= tgt + 1'b1;
                else if (!homing && mot_dec[m] && tgt != POS_RST)
                    tgt <= tgt - 1'b1;
                if (!moving) begin
                    tmr <= '0;
                end else if (!tick) begin
                    tmr <= tmr - 1'b1;
                end else begin
                    tmr <= STEP_W'(STEP_CYC_P - 1);
                    if (homing && home_sw[m]) begin
                        // A new home request in the same cycle keeps homing going
                        homing <= mot_home[m];
                        pos[m] <= POS_RST;
                        tgt <= POS_RST;
                    end else begin
                        drv[m].step <= 1'b1;
                        drv[m].up <= !homing && go_up;
                        if (!homing)
                            pos[m] <= go_up ? pos[m] + 1'b1 : pos[m] - 1'b1;
                    end
                end
            end
        end
    end
    assign cap_drv = drv[MOT_CAP];
    assign ind_drv = drv[MOT_IND];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            disp <= '0;
        end else if (ce) begin
            disp.mode <= mode;
            disp.active_l <= active_l;
            disp.out_bal <= out_bal;
            disp.bypass <= mode == FTC_BYPASS;
            disp.ant <= ant_sel;
            disp.cap_pos <= pos[MOT_CAP];
            disp.ind_pos <= pos[MOT_IND];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_press_short: assert property (ce && g_btn[0].released && g_btn[0].held <= HOLD_W'(SHORT_MAX_P) |=> press[BTN_MODE] == PR_SHORT) else $error("short press not sorted");
    a_abort_tune: assert property (ce && in_auto && mode_short && tune_busy |=> tune_abort && fine == FT_IDLE) else $error("abort missing");
    a_manual_sel: assert property (ce && in_auto && mode_short && !tuner_busy |=> mode == FTC_MANUAL) else $error("manual not selected");
    a_cfg_menu: assert property (ce && in_auto && press[BTN_MODE] == PR_MEDIUM |=> !cfg_menu_open && mode == FTC_AUTO) else $error("medium press acted");
    a_fine_start: assert property (ce && in_auto && knob_short && !tuner_busy && !consent_wait |=> fine == (hs_cfg ? FT_RUN : FT_PROMPT)) else $error("fine tune not started");
    a_consent_give: assert property (ce && in_auto && knob_short && consent_wait |=> tune_consent) else $error("consent lost");
    a_no_recall: assert property (fine != FT_IDLE |-> !recall_en) else $error("recall during fine tune");
    a_fine_store: assert property (ce && fine == FT_RUN && tune_done && !mode_short |=> store_req ##1 !store_req) else $error("store not issued once");
    a_prompt_hold: assert property (fine == FT_PROMPT |-> prompt_carrier && !fine_run) else $error("prompt not shown");
    a_out_toggle: assert property (ce && act_toggle |=> out_bal != $past(out_bal)) else $error("output not toggled");
    a_bypass_sel: assert property (ce && mode == FTC_MANUAL && mode_short |=> mode == FTC_BYPASS ##1 disp.bypass || !$past(ce)) else $error("bypass not selected");
    a_knob_swap: assert property (ce && act_swap |=> active_l != $past(active_l)) else $error("C/L not swapped");
    a_ind_limit: assert property (pos[MOT_IND] <= IND_MAX_P && g_mot[1].tgt <= IND_MAX_P) else $error("inductor out of range");
    a_boot_rehome: assert property (ce && !booted && write_intr |=> g_mot[0].homing && g_mot[1].homing) else $error("no re-home at start");
    a_disp_track: assert property (ce |=> disp.ind_pos == $past(pos[MOT_IND]) && disp.cap_pos == $past(pos[MOT_CAP])) else $error("display stale");

    c_fine_store: cover property (fine == FT_RUN ##[1:1000] store_req);
    c_bypass: cover property (mode == FTC_MANUAL ##[1:1000] mode == FTC_BYPASS);
    c_ind_step: cover property (ind_drv.step && ind_drv.up);
    c_rehome: cover property (g_mot[1].homing ##1 !g_mot[1].homing);
endmodule
`default_nettype wire

// >>> testbench/ftc_operator.sv
// Operator model: presses the three panel controls and turns the knob
`timescale 1ns/1ps
`default_nettype none
module ftc_operator (
    input wire logic mclk,
    output var ftc_pkg::ftc_panel_t panel
);
    import ftc_pkg::*;

    initial begin
        panel = '0;
    end

    // Hold one button for len cycles, then let go
    task automatic press(input int btn, input int len);
        @(posedge mclk);
        panel[btn] <= 1'b1;
        repeat (len) @(posedge mclk);
        panel[btn] <= 1'b0;
    endtask

    // Each detent is a rising edge of enc_a; enc_b low means clockwise
    task automatic rotate(input logic up, input int n);
        @(posedge mclk);
        panel.enc_b <= ~up;
        repeat (4) @(posedge mclk);
        repeat (n) begin
            panel.enc_a <= 1'b1;
            repeat (4) @(posedge mclk);
            panel.enc_a <= 1'b0;
            repeat (4) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/tb_front_panel_tuner_control.sv
// Testbench: front-panel control sequencer scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_front_panel_tuner_control;
    import ftc_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic tune_busy = 1'b0;
    logic consent_wait = 1'b0;
    logic hs_cfg = 1'b0;
    logic carrier_ok = 1'b0;
    logic tune_done = 1'b0;
    logic band_autobyp = 1'b0;
    logic write_intr = 1'b0;
    logic [1:0] home_sw = 2'h0;
    ftc_sw_t sw_cfg = SW_NONE;
    logic ce = 1'b1;
    logic [3:0] ant_sel = 4'h5;
    // Shortened timing so that every press class fits in a short run
    localparam int T_DEB = 2;
    localparam int T_SHORT = 10;
    localparam int T_MED_MIN = 20;
    localparam int T_MED_MAX = 30;
    localparam int T_LONG = 100;
    localparam int T_STEP = 4;
    localparam logic [POS_W-1:0] CAP_LIM = 10'h003;
    localparam logic [POS_W-1:0] IND_LIM = 10'h002;
    ftc_panel_t panel;
    logic tune_abort, tune_consent, cfg_menu_open, ant_menu_open, radio_menu_open;
    logic unbypass_req, fine_run, recall_en, prompt_carrier, store_req;
    ftc_motor_t cap_drv, ind_drv;
    ftc_disp_t disp;
    int cnt[9];
    int fail_count = 0;
    int n_checks = 0;
    wire logic [8:0] ev = {ind_drv.step, cap_drv.step, store_req, unbypass_req,
        radio_menu_open, ant_menu_open, cfg_menu_open, tune_consent, tune_abort};

    ftc_operator op_u (.mclk(mclk), .panel(panel));

    ftc_top #(.DEB_CYC_P(T_DEB), .SHORT_MAX_P(T_SHORT), .MED_MIN_P(T_MED_MIN),
        .MED_MAX_P(T_MED_MAX), .LONG_MIN_P(T_LONG), .STEP_CYC_P(T_STEP),
        .CAP_MAX_P(CAP_LIM), .IND_MAX_P(IND_LIM)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .ce(ce), .panel(panel), .tune_busy(tune_busy),
        .consent_wait(consent_wait), .hs_cfg(hs_cfg), .carrier_ok(carrier_ok),
        .tune_done(tune_done), .band_autobyp(band_autobyp), .sw_cfg(sw_cfg),
        .write_intr(write_intr), .home_sw(home_sw), .ant_sel(ant_sel),
        .tune_abort(tune_abort), .tune_consent(tune_consent), .cfg_menu_open(cfg_menu_open),
        .ant_menu_open(ant_menu_open), .radio_menu_open(radio_menu_open),
        .unbypass_req(unbypass_req), .fine_run(fine_run), .recall_en(recall_en),
        .prompt_carrier(prompt_carrier), .store_req(store_req), .cap_drv(cap_drv),
        .ind_drv(ind_drv), .disp(disp));

    initial begin
        forever #4 mclk = ~mclk;
    end

    // Count every cycle in which a pulse output is high
    always @(posedge mclk) begin
        foreach (cnt[i]) if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic clr();
        @(negedge mclk);
        foreach (cnt[i]) cnt[i] = 0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // One press, then time for sync, debounce and sorting to finish
    task automatic act(input int btn, input int len);
        clr();
        op_u.press(btn, len);
        wt(15);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        chk("mode", disp.mode, FTC_AUTO);
        chk("cap_pos", disp.cap_pos, POS_RST);
        chk("ind_pos", disp.ind_pos, POS_RST);
        chk("fine_run", fine_run, 1'b0);
    endtask

    task automatic t_mode_menu();
        act(BTN_MODE, 25);
        chk("cfg_med", cnt[2], 0);
        chk("mode_med", disp.mode, FTC_AUTO);
        act(BTN_MODE, 110);
        chk("cfg_long", cnt[2], 1);
        act(BTN_MODE, 15);
        chk("mode_gap", disp.mode, FTC_AUTO);
        chk("cfg_gap", cnt[2], 0);
    endtask

    task automatic t_abort();
        @(posedge mclk) tune_busy <= 1'b1;
        act(BTN_MODE, 5);
        chk("abort", cnt[0], 1);
        chk("mode_abort", disp.mode, FTC_AUTO);
        @(posedge mclk) tune_busy <= 1'b0;
    endtask

    task automatic t_fine_hs();
        @(posedge mclk) hs_cfg <= 1'b1;
        act(BTN_KNOB, 5);
        chk("fine_run", fine_run, 1'b1);
        chk("recall_en", recall_en, 1'b0);
        chk("prompt", prompt_carrier, 1'b0);
        clr();
        @(posedge mclk) tune_done <= 1'b1;
        @(posedge mclk) tune_done <= 1'b0;
        wt(5);
        chk("store", cnt[6], 1);
        chk("fine_end", fine_run, 1'b0);
        @(posedge mclk) hs_cfg <= 1'b0;
    endtask

    task automatic t_fine_prompt();
        act(BTN_KNOB, 5);
        chk("prompt", prompt_carrier, 1'b1);
        chk("fine_wait", fine_run, 1'b0);
        @(posedge mclk) carrier_ok <= 1'b1;
        wt(4);
        chk("fine_go", fine_run, 1'b1);
        act(BTN_MODE, 5);
        chk("abort_ft", cnt[0], 1);
        chk("fine_off", fine_run, 1'b0);
        chk("mode_ft", disp.mode, FTC_AUTO);
        @(posedge mclk) carrier_ok <= 1'b0;
    endtask

    task automatic t_consent();
        @(posedge mclk) consent_wait <= 1'b1;
        act(BTN_KNOB, 5);
        chk("consent", cnt[1], 1);
        chk("no_fine", fine_run, 1'b0);
        @(posedge mclk) consent_wait <= 1'b0;
    endtask

    task automatic t_output();
        @(posedge mclk) band_autobyp <= 1'b1;
        act(BTN_OUT, 5);
        chk("unbyp", cnt[5], 1);
        chk("bal_keep", disp.out_bal, 1'b0);
        @(posedge mclk) band_autobyp <= 1'b0;
        act(BTN_OUT, 5);
        chk("bal_tog", disp.out_bal, 1'b1);
        chk("unbyp_no", cnt[5], 0);
        @(posedge mclk) sw_cfg <= SW_OUTPUT;
        act(BTN_OUT, 5);
        chk("ant_menu", cnt[3], 1);
        chk("bal_ant", disp.out_bal, 1'b1);
        @(posedge mclk) sw_cfg <= SW_INPUT;
        act(BTN_OUT, 25);
        chk("radio_menu", cnt[4], 1);
        @(posedge mclk) sw_cfg <= SW_NONE;
    endtask

    // Clock enable low: a whole press goes unseen and no state moves
    task automatic t_freeze();
        @(posedge mclk) ce <= 1'b0;
        act(BTN_OUT, 5);
        chk("frz_bal", disp.out_bal, 1'b1);
        chk("frz_pulse", cnt[5] + cnt[3], 0);
        @(posedge mclk) ce <= 1'b1;
        act(BTN_OUT, 5);
        chk("run_bal", disp.out_bal, 1'b0);
    endtask

    task automatic t_manual();
        clr();
        op_u.rotate(1'b1, 2);
        wt(20);
        chk("auto_rot", cnt[7], 0);
        act(BTN_MODE, 5);
        chk("manual", disp.mode, FTC_MANUAL);
        chk("ant", disp.ant, 4'h5);
        @(posedge mclk) ant_sel <= 4'ha;
        wt(3);
        chk("ant_new", disp.ant, 4'ha);
        clr();
        op_u.rotate(1'b1, 5);
        wt(40);
        chk("cap_max", disp.cap_pos, CAP_LIM);
        chk("cap_steps", cnt[7], 3);
        op_u.rotate(1'b0, 1);
        wt(20);
        chk("cap_dn", disp.cap_pos, 10'h002);
        chk("cap_dir", cap_drv.up, 1'b0);
        act(BTN_KNOB, 5);
        chk("l_active", disp.active_l, 1'b1);
        clr();
        op_u.rotate(1'b1, 4);
        wt(40);
        chk("ind_max", disp.ind_pos, IND_LIM);
        chk("ind_steps", cnt[8], 2);
        chk("ind_dir", ind_drv.up, 1'b1);
        chk("cap_hold", disp.cap_pos, 10'h002);
        act(BTN_KNOB, 110);
        @(posedge mclk) home_sw <= 2'h2;
        wt(12);
        chk("ind_home", disp.ind_pos, 10'h000);
        act(BTN_MODE, 5);
        chk("bypass", disp.mode, FTC_BYPASS);
        chk("byp_flag", disp.bypass, 1'b1);
        act(BTN_MODE, 5);
        chk("back_auto", disp.mode, FTC_AUTO);
    endtask

    task automatic t_rehome();
        @(posedge mclk) begin
            write_intr <= 1'b1;
            home_sw <= 2'h0;
            reset_n <= 1'b0;
        end
        wt(16);
        @(posedge mclk) reset_n <= 1'b1;
        clr();
        wt(20);
        chk("cap_rehome", cnt[7] > 0, 1);
        chk("ind_rehome", cnt[8] > 0, 1);
        @(posedge mclk) home_sw <= 2'h3;
        wt(10);
        clr();
        wt(20);
        chk("rehome_end", cnt[7] + cnt[8], 0);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        end_sim();
    end

    initial begin
        wt(16);
        @(posedge mclk) reset_n <= 1'b1;
        wt(4);
        t_reset();
        t_mode_menu();
        t_abort();
        t_fine_hs();
        t_fine_prompt();
        t_consent();
        t_output();
        t_freeze();
        t_manual();
        t_rehome();
        end_sim();
    end
endmodule
`default_nettype wire
